// >>> logic/cpu_clk_divider.sv
// Programmable CPU clock tick divider with half rate option
`default_nettype none
module cpu_clk_divider
  import osc_ctrl_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input  wire logic             pclk,     // Selected oscillator clock
  input  wire logic             presetn,  // Async reset, active low
  input  wire logic             ce,       // Clock enable
  input  wire logic             run,      // Oscillator running
  input  wire logic             half,     // Divide by two when divider setting is zero
  input  wire logic [DIV_W-1:0] cpu_clock_divider,     // Divider setting
  output logic                  tick      // One CPU clock tick
);

  div_state_t state;
  div_state_t next_state;
  logic [8:0] limit;

  // Terminal count: 2*(N+1)-1, or 1 for half rate, or 0 for none; compared live so
  // a rewrite takes effect in the period under way without stalling
  always_comb begin
    if (cpu_clock_divider != '0) begin
      limit = 9'((10'(cpu_clock_divider) + 10'h001) * 10'h002 - 10'h001);
    end else if (half) begin
      limit = 9'h001;
    end else begin
      limit = 9'h000;
    end
    next_state = state;
    next_state.tick = 1'b0;
    if (run) begin
      if (state.count >= limit) begin
        next_state.count = 9'h000;
        next_state.tick  = 1'b1;
      end else begin
        next_state.count = state.count + 9'h001;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign tick = state.tick;

endmodule
`default_nettype wire

// >>> logic/osc_select_and_clock_output.sv
// Oscillator source selection, CPU clock divider control and clock output
`default_nettype none
module osc_select_and_clock_output
  import osc_ctrl_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input  wire logic        pclk,          // Clock from selected oscillator
  input  wire logic        presetn,       // Async reset, active low
  input  wire logic        ce,            // Clock enable, freezes all state
  input  wire apb_req_t    apb_req,       // APB request
  output apb_rsp_t         apb_rsp,       // APB answer
  input  wire logic        wake,          // Wake event from power down
  input  wire logic        port_out,      // Port latch value for second pin
  input  wire logic        port_oe_n,     // Port drive enable, active low
  output logic             clock_out_pin, // Second pin output value
  output logic             pin_oe_n,      // Second pin output enable, active low
  output logic             osc_run,       // Oscillator enable
  output logic             cpu_tick,      // CPU clock tick
  output logic             cpu_hold       // Execution held until stable
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [2:0]       src;
    logic             half;
    logic             locked;
    logic [DIV_W-1:0] cpu_clock_divider;
    logic [7:0]       port2_mode_reg_one;
    pwr_state_t       pwr;
    logic [10:0]      stab;
    logic [1:0]       phase;
    logic             clk_q;
    logic             clk_act;
    logic             pin_q;
    logic             oe_n_q;
    logic             run_q;
    logic             tick_q;
    logic             hold_q;
    apb_rsp_t         rsp;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;
  logic       tick;
  logic       wr_en;
  logic       rd_en;
  logic       clk_src_ok;
  logic       is_ext;
  logic [31:0] rdata;

  // ************************************************************
  // Divider
  // ************************************************************
  cpu_clk_divider #(
    .DIV_W (DIV_W)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .run     (state.run_q),
    .half    (state.half),
    .cpu_clock_divider    (state.cpu_clock_divider),
    .tick    (tick)
  );

  // Decode of APB and source options
  always_comb begin
    wr_en      = apb_req.psel && apb_req.penable && apb_req.pwrite && !state.rsp.pready;
    rd_en      = apb_req.psel && apb_req.penable && !apb_req.pwrite && !state.rsp.pready;
    clk_src_ok = (state.src == SRC_RC) || (state.src == SRC_EXT);
    is_ext     = (state.src == SRC_EXT);
    unique case (apb_req.paddr)
      ADDR_CFG:    rdata = {24'h000000, state.locked, 3'h0, state.half, state.src};
      ADDR_DIV:    rdata = 32'(state.cpu_clock_divider);
      ADDR_PORT2_MODE_REG_ONE:   rdata = {24'h000000, state.port2_mode_reg_one};
      ADDR_STATUS: rdata = {27'h0000000, state.hold_q, state.clk_act, state.pwr,
                            state.run_q};
      default:     rdata = 32'h00000000;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_state = state;

    // APB slave: one wait state, answer in the access phase's second cycle
    next_state.rsp.pready  = rd_en || wr_en;
    next_state.rsp.pslverr = 1'b0;
    next_state.rsp.prdata  = 32'h00000000;
    if (rd_en || wr_en) begin
      next_state.rsp.pslverr = !(apb_req.paddr inside {ADDR_CFG, ADDR_DIV, ADDR_PORT2_MODE_REG_ONE,
                                                       ADDR_STATUS});
    end
    if (rd_en) begin
      next_state.rsp.prdata = rdata;
    end
    if (wr_en) begin
      unique case (apb_req.paddr)
        ADDR_CFG: begin
          // Written once at programming, then locked
          if (!state.locked && apb_req.pwdata[2:0] <= 3'(SRC_EXT)) begin
            next_state.src    = apb_req.pwdata[CFG_SRC_LSB +: 3];
            next_state.half   = apb_req.pwdata[CFG_HALF_BIT];
            next_state.locked = 1'b1;
          end
        end
        ADDR_DIV:  next_state.cpu_clock_divider = apb_req.pwdata[DIV_W-1:0];
        ADDR_PORT2_MODE_REG_ONE: next_state.port2_mode_reg_one = apb_req.pwdata[7:0];
        default: ;
      endcase
    end

    // Power sequencing
    unique case (state.pwr)
      PWR_RUN: begin
        if (state.port2_mode_reg_one[PORT2_MODE_REG_ONE_PD_BIT]) begin
          next_state.pwr = PWR_DOWN;
          next_state.port2_mode_reg_one[PORT2_MODE_REG_ONE_PD_BIT] = 1'b0;
        end else if (state.port2_mode_reg_one[PORT2_MODE_REG_ONE_IDLE_BIT]) begin
          next_state.pwr = PWR_IDLE;
          next_state.port2_mode_reg_one[PORT2_MODE_REG_ONE_IDLE_BIT] = 1'b0;
        end
      end
      PWR_IDLE: begin
        if (wake) begin
          next_state.pwr = PWR_RUN;
        end
      end
      PWR_DOWN: begin
        if (wake) begin
          next_state.pwr  = PWR_WAKE;
          next_state.stab = clk_src_ok ? RC_STABLE_CYC : XTAL_STABLE_CYC;
        end
      end
      PWR_WAKE: begin
        next_state.stab = state.stab - 11'h001;
        if (state.stab == 11'h001) begin
          next_state.pwr = PWR_RUN;
        end
      end
    endcase
    next_state.run_q  = (next_state.pwr != PWR_DOWN);
    next_state.hold_q = (next_state.pwr == PWR_WAKE) || (next_state.pwr == PWR_DOWN);
    // No CPU tick leaves the block once the oscillator is stopped
    next_state.tick_q = tick && next_state.run_q;

    // Clock output: divide CPU ticks by six, enable sampled at low boundary
    if (tick && state.run_q) begin
      if (state.phase == CLKOUT_HALF_TICKS - 2'h1) begin
        next_state.phase = 2'h0;
        next_state.clk_q = !state.clk_q && state.clk_act;
        if (state.clk_q || !state.clk_act) begin
          next_state.clk_act = state.port2_mode_reg_one[PORT2_MODE_REG_ONE_CLK_BIT] && clk_src_ok;
        end
      end else begin
        next_state.phase = state.phase + 2'h1;
      end
    end
    if (!state.clk_act && state.clk_q) begin
      next_state.clk_q = 1'b0;
    end

    // Second pin: clock output, port, or held by the crystal
    if (state.clk_act) begin
      next_state.pin_q  = state.clk_q;
      next_state.oe_n_q = 1'b0;
    end else if (is_ext) begin
      next_state.pin_q  = port_out;
      next_state.oe_n_q = port_oe_n;
    end else if (state.src == SRC_RC) begin
      next_state.pin_q  = port_out;
      next_state.oe_n_q = port_oe_n;
    end else begin
      next_state.pin_q  = 1'b0;
      next_state.oe_n_q = 1'b1;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= '0;
      state.src    <= SRC_XTAL_LOW;
      state.cpu_clock_divider   <= DIV_RESET[DIV_W-1:0];
      state.port2_mode_reg_one   <= PORT2_MODE_REG_ONE_RESET;
      state.pwr    <= PWR_RUN;
      state.oe_n_q <= 1'b1;
      state.run_q  <= 1'b1;
    end else if (ce) begin
      state <= next_state; // Fully static, any pclk rate down to a stopped clock
    end
  end

  // Outputs straight from flip-flops
  assign apb_rsp       = state.rsp;
  assign clock_out_pin = state.pin_q;
  assign pin_oe_n      = state.oe_n_q;
  assign osc_run       = state.run_q;
  assign cpu_tick      = state.tick_q;
  assign cpu_hold      = state.hold_q;

endmodule
`default_nettype wire

// >>> pkg/osc_ctrl_pkg.sv
// Constants, types and register map of the oscillator select and clock output block
`default_nettype none
package osc_ctrl_pkg;

  // ************************************************************
  // Register map (byte addresses on APB)
  // ************************************************************
  localparam logic [11:0] ADDR_CFG    = 12'h000; // Config word: source select, half rate
  localparam logic [11:0] ADDR_DIV    = 12'h004; // CPU clock divider
  localparam logic [11:0] ADDR_PORT2_MODE_REG_ONE   = 12'h008; // Port 2 mode register one
  localparam logic [11:0] ADDR_STATUS = 12'h00c; // Status, read only

  // Field positions
  localparam int CFG_SRC_LSB   = 0;  // Source option, three bits
  localparam int CFG_HALF_BIT  = 3;  // Half rate configuration bit
  localparam int CFG_LOCK_BIT  = 7;  // Config written, now locked
  localparam int PORT2_MODE_REG_ONE_CLK_BIT  = 1;  // Clock output enable bit
  localparam int PORT2_MODE_REG_ONE_IDLE_BIT = 2;  // Idle request
  localparam int PORT2_MODE_REG_ONE_PD_BIT   = 3;  // Power down request

  // Reset values
  localparam logic [7:0] DIV_RESET  = 8'h00;
  localparam logic [7:0] PORT2_MODE_REG_ONE_RESET = 8'h00;

  // Stability counts after power down wake
  localparam logic [10:0] XTAL_STABLE_CYC = 11'h400; // 1024 clocks
  localparam logic [10:0] RC_STABLE_CYC   = 11'h100; // 256 clocks

  // Output clock is one sixth of CPU clock: three CPU ticks per half period
  localparam logic [1:0]  CLKOUT_HALF_TICKS = 2'h3;

  // Clock source options
  typedef enum logic [2:0] {
    SRC_XTAL_LOW  = 3'b000,
    SRC_XTAL_MED  = 3'b001,
    SRC_XTAL_HIGH = 3'b010,
    SRC_RC        = 3'b011,
    SRC_EXT       = 3'b100
  } osc_src_t;

  // Power state
  typedef enum logic [1:0] {
    PWR_RUN   = 2'b00,
    PWR_IDLE  = 2'b01,
    PWR_DOWN  = 2'b10,
    PWR_WAKE  = 2'b11
  } pwr_state_t;

  // APB request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // APB answer bundle
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // Divider state
  typedef struct packed {
    logic [8:0] count;
    logic       tick;
  } div_state_t;

endpackage
`default_nettype wire

// >>> tb/clk_sink_model.sv
// External device that locks onto the output clock and times its levels
`default_nettype none
module clk_sink_model (
  input  wire logic  pclk,     // Sampling clock
  input  wire logic  pin,      // Output clock pin
  input  wire logic  pin_oe_n, // Pin drive enable, active low
  output logic [15:0] hi_len,  // Last high time in cycles
  output logic [15:0] lo_len,  // Last low time in cycles
  output logic [15:0] edges    // Edges seen while driven
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run_len = 16'h0;
  logic        last = 1'b0;
  initial hi_len = 16'h0;
  initial lo_len = 16'h0;
  initial edges = 16'h0;
  // Time each level so a runt or wrong ratio shows up
  always @(posedge pclk) begin
    last <= pin;
    run_len <= (pin_oe_n || pin !== last) ? 16'h0 : run_len + 16'h1;
    if (!pin_oe_n && pin !== last) begin
      edges <= edges + 16'h1;
      if (last) hi_len <= run_len + 16'h1;
      else lo_len <= run_len + 16'h1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/osc_clkout_props.sv
// Port checker for the oscillator select and clock output block
`default_nettype none
module osc_clkout_props
  import osc_ctrl_pkg::*;
(
  input wire logic     pclk,          // Clock
  input wire logic     presetn,       // Async reset, active low
  input wire logic     ce,            // Clock enable
  input wire apb_req_t apb_req,       // APB request
  input wire apb_rsp_t apb_rsp,       // APB answer
  input wire logic     wake,          // Wake event
  input wire logic     port_out,      // Port latch value
  input wire logic     port_oe_n,     // Port drive enable
  input wire logic     clock_out_pin, // Second pin value
  input wire logic     pin_oe_n,      // Second pin enable
  input wire logic     osc_run,       // Oscillator enable
  input wire logic     cpu_tick,      // CPU tick
  input wire logic     cpu_hold       // Execution hold
);
  // ********************
  // Port relations
  // ********************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wait; apb_req.psel && !apb_req.penable |=> !apb_rsp.pready; endproperty
  a_wait: assert property (p_wait) else $error("answer without wait state");
  property p_ready; apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready;
  endproperty
  a_ready: assert property (p_ready) else $error("answer late");
  property p_pulse; apb_rsp.pready |=> !apb_rsp.pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_err; apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error read not zero");
  property p_freeze; !ce |=> $stable({clock_out_pin, pin_oe_n, cpu_tick, osc_run, cpu_hold});
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock stopped");
  property p_down; !osc_run |-> cpu_hold && !cpu_tick; endproperty
  a_down: assert property (p_down) else $error("ticks in power down");
  property p_wake; $rose(osc_run) |-> cpu_hold [*8]; endproperty
  a_wake: assert property (p_wake) else $error("hold dropped early");
  property p_rel; $fell(cpu_hold) |-> osc_run; endproperty
  a_rel: assert property (p_rel) else $error("hold released while stopped");
endmodule
bind osc_select_and_clock_output osc_clkout_props i_props (.pclk, .presetn, .ce, .apb_req,
  .apb_rsp, .wake, .port_out, .port_oe_n, .clock_out_pin, .pin_oe_n, .osc_run, .cpu_tick,
  .cpu_hold);
`default_nettype wire

// >>> tb/osc_select_and_clock_output_tb.sv
// Self-checking bench of the oscillator select and clock output block
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module osc_select_and_clock_output_tb
  import osc_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, ce, wake, port_out, port_oe_n;
  logic clock_out_pin, pin_oe_n, osc_run, cpu_tick, cpu_hold;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  logic [15:0] hi_len, lo_len, edges, e0;
  int bad_count = 0;
  int cmp_count = 0;
  osc_select_and_clock_output i_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .wake(wake), .port_out(port_out),
    .port_oe_n(port_oe_n), .clock_out_pin(clock_out_pin), .pin_oe_n(pin_oe_n),
    .osc_run(osc_run), .cpu_tick(cpu_tick), .cpu_hold(cpu_hold));
  clk_sink_model i_sink (.pclk(pclk), .pin(clock_out_pin), .pin_oe_n(pin_oe_n),
    .hi_len(hi_len), .lo_len(lo_len), .edges(edges));
  // ********************
  // Tasks
  // ********************
  task automatic complete_run;
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (apb_rsp.pready !== 1'b1 && n < 64);
    if (n >= 64) begin bad_count++; complete_run(); end
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge pclk); // Idle cycle between transfers
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK(q, x)
    `CHK(e, xe)
  endtask
  task automatic clk_chk(input int cyc, input logic [15:0] half);
    repeat (cyc) @(posedge pclk);
    `CHK(hi_len, half)
    `CHK(lo_len, half)
  endtask
  task automatic s_crystal;
    rd(ADDR_DIV, 32'h0, 1'b0);
    rd(12'h010, 32'h0, 1'b1);
    wr(ADDR_PORT2_MODE_REG_ONE, 32'h2);
    repeat (30) @(posedge pclk);
    `CHK(pin_oe_n, 1'b1)
    wr(ADDR_CFG, 32'h3);
    wr(ADDR_CFG, 32'h0);
    rd(ADDR_CFG, 32'h83, 1'b0);
    clk_chk(60, 16'd3);
  endtask
  task automatic s_div;
    int n;
    n = 0;
    wr(ADDR_DIV, 32'h1);
    clk_chk(100, 16'd12);
    // One CPU tick per four clocks at this setting
    repeat (40) begin
      @(posedge pclk);
      if (cpu_tick === 1'b1) n++;
    end
    `CHK(n, 10)
    wr(ADDR_DIV, 32'hff);
    clk_chk(5200, 16'd1536);
    wr(ADDR_DIV, 32'h0);
    clk_chk(60, 16'd3);
  endtask
  task automatic s_power;
    wr(ADDR_PORT2_MODE_REG_ONE, 32'h6);
    e0 = edges;
    repeat (60) @(posedge pclk);
    `CHK(edges - e0 > 16'd15, 1'b1)
    rd(ADDR_STATUS, 32'hb, 1'b0);
    wake <= 1'b1;
    @(posedge pclk);
    wake <= 1'b0;
    // Software drops the output before idle, so the pin goes quiet
    wr(ADDR_PORT2_MODE_REG_ONE, 32'h4);
    repeat (12) @(posedge pclk);
    e0 = edges;
    repeat (20) @(posedge pclk);
    `CHK({edges == e0, pin_oe_n}, 2'b11)
    wake <= 1'b1;
    @(posedge pclk);
    wake <= 1'b0;
    wr(ADDR_PORT2_MODE_REG_ONE, 32'ha);
    repeat (4) @(posedge pclk);
    e0 = edges;
    `CHK({osc_run, cpu_hold}, 2'b01)
    repeat (20) @(posedge pclk);
    `CHK(edges, e0)
    wake <= 1'b1;
    for (int n = 0; n < 2000; n++) begin
      @(posedge pclk);
      wake <= 1'b0;
      if (cpu_hold === 1'b0) begin
        `CHK(n >= 255 && n <= 260, 1'b1)
        break;
      end
    end
    `CHK(cpu_hold, 1'b0)
  endtask
  task automatic s_static;
    ce <= 1'b0;
    repeat (2) @(posedge pclk);
    e0 = edges;
    repeat (40) @(posedge pclk);
    `CHK(edges, e0)
    ce <= 1'b1;
    clk_chk(60, 16'd3);
  endtask
  task automatic s_ext;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(ADDR_CFG, 32'hc);
    port_out <= 1'b1;
    port_oe_n <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK({clock_out_pin, pin_oe_n}, 2'b10)
    port_out <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK(clock_out_pin, 1'b0)
    wr(ADDR_PORT2_MODE_REG_ONE, 32'h2);
    clk_chk(100, 16'd6);
    wr(ADDR_PORT2_MODE_REG_ONE, 32'h0);
    port_out <= 1'b1;
    repeat (30) @(posedge pclk);
    `CHK(clock_out_pin, 1'b1)
  endtask
  // Free-running clock, 4 ns period
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Main sequence
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    wake = 1'b0;
    port_out = 1'b0;
    port_oe_n = 1'b1;
    apb_req = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_crystal();
    s_div();
    s_power();
    s_static();
    s_ext();
    complete_run();
  end
endmodule
`default_nettype wire
